// ==== logic/cwrs_consts.vh ====
// register offsets, field positions, reset values and scaling for the config/reference block
`ifndef CWRS_CONSTS_VH
`define CWRS_CONSTS_VH

// printed locations are not multiples of four: byte address is four times the index
`define CWRS_IDX_CONFIG        8'h0A
`define CWRS_IDX_STORED_REF    8'h0F
`define CWRS_IDX_VAR_LIMIT     8'h10
`define CWRS_IDX_TRIM_VOLTAGE_TRIM_P   8'h13
`define CWRS_IDX_TRIM_STABILITY_TRIM_P   8'h14
`define CWRS_IDX_TRIM_HZ_P     8'h15
`define CWRS_IDX_TRIM_AMP_P    8'h16
`define CWRS_IDX_STATUS_CFG    8'h27
`define CWRS_IDX_VOLATILE_REF  8'h31
`define CWRS_IDX_ACTIVE_REF    8'h2A
`define CWRS_IDX_REF_STATUS    8'h40

// configuration word layout
`define CWRS_BIT_RMS           0
`define CWRS_BIT_PERIODIC      1
`define CWRS_BIT_OFFSET_COMP   2
`define CWRS_BIT_LAST32        3
`define CWRS_BIT_ALARM_INV     5
`define CWRS_BIT_RAM_REF       7
`define CWRS_BIT_TRIM_VOLTAGE_TRIM     8
`define CWRS_BIT_TRIM_STABILITY_TRIM     9
`define CWRS_BIT_TRIM_HZ       10
`define CWRS_BIT_TRIM_AMP      11
`define CWRS_BIT_ANALOG_EN     12
`define CWRS_BIT_DAC_EN        13
`define CWRS_BIT_SEL_60HZ      14

// reset values
`define CWRS_RST_CONFIG        16'h1F3D
`define CWRS_RST_STORED_REF    16'h4000
`define CWRS_RST_VAR_LIMIT     16'h1200
`define CWRS_RST_TRIM_VOLTAGE_TRIM_P   16'h0000
`define CWRS_RST_TRIM_STABILITY_TRIM_P   16'h4000
`define CWRS_RST_TRIM_HZ_P     16'h4000
`define CWRS_RST_TRIM_AMP_P    16'h4000

// reference scaling: mid-scale plus limit; 15-bit full scale
`define CWRS_REF_MID           16'h4000
`define CWRS_REF_FULL          16'h7FFF
`define CWRS_AXI_OKAY          2'h0
`define CWRS_AXI_SLVERR        2'h2

`endif

// ==== logic/cwrs_ref_select.v ====
// reference source choice among analogue, clamped analogue, stored and volatile values
`timescale 1ns/1ps
`include "cwrs_consts.vh"

module cwrs_ref_select (
    // control
    input  wire        analog_en,
    input  wire        ram_ref_flag,
    // candidate sources
    input  wire [15:0] analog_value,
    input  wire        analog_at_limit,
    input  wire        analog_lost,
    input  wire [15:0] var_limit,
    input  wire [15:0] stored_ref,
    input  wire [15:0] volatile_ref,
    // result
    output reg  [15:0] ref_value,
    output reg  [1:0]  ref_source,
    output reg         ref_clamped
);

    wire [16:0] ref_max_wide;
    wire [15:0] ref_max;

    // top of remote range: mid-scale plus the variation limit, saturated
    assign ref_max_wide = {1'b0, `CWRS_REF_MID} + {1'b0, var_limit};
    assign ref_max      = (ref_max_wide > {1'b0, `CWRS_REF_FULL}) ? `CWRS_REF_FULL
                                                                   : ref_max_wide[15:0];

    always @* begin
        ref_value   = stored_ref;
        ref_source  = {analog_en, ram_ref_flag};
        ref_clamped = 1'b0;
        case ({analog_en, ram_ref_flag}) // R15
            2'b10: begin
                ref_value = analog_value;
            end
            2'b11: begin
                if (analog_lost) begin
                    ref_value   = ref_max; // R10
                    ref_clamped = 1'b1;
                end else if (analog_at_limit || analog_value > ref_max) begin
                    ref_value   = ref_max; // R9
                    ref_clamped = 1'b1;
                end else begin
                    ref_value = analog_value;
                end
            end
            2'b00: begin
                ref_value = stored_ref; // R11
            end
            2'b01: begin
                ref_value = volatile_ref; // R13
            end
            default: begin
                ref_value = stored_ref;
            end
        endcase
    end

endmodule // cwrs_ref_select

// ==== logic/cwrs_config_bank.v ====
// configuration word bank with AXI4-Lite slave and voltage reference selection
//
// Contract
// R1: each configuration bit enables its function when one, disables it when zero
// R2: software writes the word as a sum of weights; default totals 7997
// R3: at reset bits 0, 2-5 and 8-12 are set, all others clear
// R4: bit 2 enables automatic offset compensation of voltage acquisition
// R5: bit 3 makes voltage measurement use only the last 32 samples
// R6: bit 12 enables the external analogue remote voltage input
// R7: bit 14 selects 60 Hz when the frequency jumper is disabled
// R8: bit 7 is the RAM reference flag, meaning depends on analogue enable
// R9: analogue enabled plus flag set clamps reference at input limit
// R10: with saturation, lost analogue link drives reference to variation maximum
// R11: stored mode loads volatile location from stored value and tracks it
// R12: in stored mode writes to the volatile location do not steer regulation
// R13: analogue disabled plus flag set uses the volatile location as reference
// R14: bits 8-11 choose trimmer reading or stored parameter for four settings
// R15: source choice is combinational from analogue enable and RAM flag
`timescale 1ns/1ps
`include "cwrs_consts.vh"

module cwrs_config_bank #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // analogue remote input and front-panel trimmers (pins)
    input  wire [15:0]       analog_value_pin,
    input  wire              analog_at_limit_pin,
    input  wire              analog_lost_pin,
    input  wire [15:0]       voltage_trim,
    input  wire [15:0]       stability_trim,
    input  wire [15:0]       underspeed_trim,
    input  wire [15:0]       excitation_current_trim,
    input  wire              freq_jumper_en_pin,
    input  wire              freq_jumper_60_pin,
    // function enables to the regulator
    output reg               true_rms_regulation,
    output reg               periodic_ref_en,
    output reg               offset_comp_en,
    output reg               last32_samples_en,
    output reg               aux_alarm_output_invert,
    output reg               analog_input_en,
    output reg               ext_dac_en,
    output reg               nominal_60hz,
    // selected values to the regulator
    output reg  [15:0]       voltage_ref,
    output reg  [1:0]        voltage_ref_source,
    output reg               voltage_ref_clamped,
    output reg  [15:0]       ref_setting,
    output reg  [15:0]       stability_setting,
    output reg  [15:0]       underspeed_setting,
    output reg  [15:0]       excitation_current_setting
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers (two flops each; stage 1 read only by stage 2)

    localparam SYNC_W = 16 * 5 + 4;

    wire [SYNC_W-1:0] sync_in;
    reg  [SYNC_W-1:0] sync1_reg;
    reg  [SYNC_W-1:0] sync2_reg;

    assign sync_in = {analog_value_pin, voltage_trim, stability_trim, underspeed_trim,
                      excitation_current_trim, analog_at_limit_pin, analog_lost_pin,
                      freq_jumper_en_pin, freq_jumper_60_pin};

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= {SYNC_W{1'b0}};
            sync2_reg <= {SYNC_W{1'b0}};
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire [15:0] analog_s    = sync2_reg[83:68];
    wire [15:0] trim_voltage_trim_s = sync2_reg[67:52];
    wire [15:0] trim_stability_trim_s = sync2_reg[51:36];
    wire [15:0] trim_hz_s   = sync2_reg[35:20];
    wire [15:0] trim_amp_s  = sync2_reg[19:4];
    wire        at_limit_s  = sync2_reg[3];
    wire        lost_s      = sync2_reg[2];
    wire        jumper_en_s = sync2_reg[1];
    wire        jumper_60_s = sync2_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg [15:0] config_reg;
    reg [15:0] stored_ref_reg;
    reg [15:0] var_limit_reg;
    reg [15:0] trim_param_reg [0:3];
    reg [15:0] volatile_ref_reg;

    // byte address to word index; byte offset bits ignored
    function [7:0] word_index;
        input [ADDR_W-1:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0]  wstrb;
        begin
            merge16[7:0]  = wstrb[0] ? wdata[7:0]  : old_val[7:0];
            merge16[15:8] = wstrb[1] ? wdata[15:8] : old_val[15:8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data captured independently, either order

    reg              aw_held_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg              w_held_reg;
    reg [31:0]       w_data_reg;
    reg [3:0]        w_strb_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [7:0] wr_idx   = word_index(aw_addr_reg);
    wire       wr_hit   = (wr_idx == `CWRS_IDX_CONFIG) || (wr_idx == `CWRS_IDX_STORED_REF) ||
                          (wr_idx == `CWRS_IDX_VAR_LIMIT) || (wr_idx == `CWRS_IDX_VOLATILE_REF) ||
                          (wr_idx >= `CWRS_IDX_TRIM_VOLTAGE_TRIM_P && wr_idx <= `CWRS_IDX_TRIM_AMP_P);

    // stored-reference mode: volatile location tracks the stored value
    wire stored_mode = !config_reg[`CWRS_BIT_ANALOG_EN] && !config_reg[`CWRS_BIT_RAM_REF];

    integer i;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg      <= 1'b0;
            aw_addr_reg      <= {ADDR_W{1'b0}};
            w_held_reg       <= 1'b0;
            w_data_reg       <= 32'h00000000;
            w_strb_reg       <= 4'h0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= `CWRS_AXI_OKAY;
            config_reg       <= `CWRS_RST_CONFIG; // R3 R2
            stored_ref_reg   <= `CWRS_RST_STORED_REF;
            var_limit_reg    <= `CWRS_RST_VAR_LIMIT;
            trim_param_reg[0] <= `CWRS_RST_TRIM_VOLTAGE_TRIM_P;
            trim_param_reg[1] <= `CWRS_RST_TRIM_STABILITY_TRIM_P;
            trim_param_reg[2] <= `CWRS_RST_TRIM_HZ_P;
            trim_param_reg[3] <= `CWRS_RST_TRIM_AMP_P;
            // start-up load from the stored reference
            volatile_ref_reg <= `CWRS_RST_STORED_REF; // R11
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `CWRS_AXI_OKAY : `CWRS_AXI_SLVERR;
                if (wr_idx == `CWRS_IDX_CONFIG)
                    config_reg <= merge16(config_reg, w_data_reg, w_strb_reg); // R1
                if (wr_idx == `CWRS_IDX_STORED_REF)
                    stored_ref_reg <= merge16(stored_ref_reg, w_data_reg, w_strb_reg);
                if (wr_idx == `CWRS_IDX_VAR_LIMIT)
                    var_limit_reg <= merge16(var_limit_reg, w_data_reg, w_strb_reg);
                for (i = 0; i < 4; i = i + 1) begin
                    if (wr_idx == `CWRS_IDX_TRIM_VOLTAGE_TRIM_P + i[7:0])
                        trim_param_reg[i] <= merge16(trim_param_reg[i], w_data_reg, w_strb_reg);
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // tracking overrides any write to the volatile location
            if (stored_mode)
                volatile_ref_reg <= stored_ref_reg; // R11 R12
            else if (do_write && wr_idx == `CWRS_IDX_VOLATILE_REF)
                volatile_ref_reg <= merge16(volatile_ref_reg, w_data_reg, w_strb_reg); // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle to rdata

    wire [15:0] sel_ref;
    wire [1:0]  sel_src;
    wire        sel_clamp;

    assign s_axi_arready = !s_axi_rvalid;

    wire [7:0] rd_idx = word_index(s_axi_araddr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CWRS_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CWRS_AXI_OKAY;
            case (rd_idx)
                `CWRS_IDX_CONFIG:       s_axi_rdata <= {16'h0000, config_reg};
                `CWRS_IDX_STORED_REF:   s_axi_rdata <= {16'h0000, stored_ref_reg};
                `CWRS_IDX_VAR_LIMIT:    s_axi_rdata <= {16'h0000, var_limit_reg};
                `CWRS_IDX_TRIM_VOLTAGE_TRIM_P:  s_axi_rdata <= {16'h0000, trim_param_reg[0]};
                `CWRS_IDX_TRIM_STABILITY_TRIM_P:  s_axi_rdata <= {16'h0000, trim_param_reg[1]};
                `CWRS_IDX_TRIM_HZ_P:    s_axi_rdata <= {16'h0000, trim_param_reg[2]};
                `CWRS_IDX_TRIM_AMP_P:   s_axi_rdata <= {16'h0000, trim_param_reg[3]};
                `CWRS_IDX_VOLATILE_REF: s_axi_rdata <= {16'h0000, volatile_ref_reg};
                `CWRS_IDX_ACTIVE_REF:   s_axi_rdata <= {16'h0000, sel_ref};
                `CWRS_IDX_STATUS_CFG: begin
                    // active configuration: bit 14 reflects the effective frequency choice
                    s_axi_rdata <= {16'h0000, config_reg[15], nominal_60hz, config_reg[13:0]};
                end
                `CWRS_IDX_REF_STATUS:   s_axi_rdata <= {29'h00000000, sel_clamp, sel_src};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CWRS_AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference source selection

    cwrs_ref_select u_ref_select (
        .analog_en       (config_reg[`CWRS_BIT_ANALOG_EN]),
        .ram_ref_flag    (config_reg[`CWRS_BIT_RAM_REF]), // R8
        .analog_value    (analog_s),
        .analog_at_limit (at_limit_s),
        .analog_lost     (lost_s),
        .var_limit       (var_limit_reg),
        .stored_ref      (stored_ref_reg),
        .volatile_ref    (volatile_ref_reg),
        .ref_value       (sel_ref),
        .ref_source      (sel_src),
        .ref_clamped     (sel_clamp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs to the regulator

    always @(posedge aclk) begin
        if (!aresetn) begin
            true_rms_regulation        <= 1'b0;
            periodic_ref_en            <= 1'b0;
            offset_comp_en             <= 1'b0;
            last32_samples_en          <= 1'b0;
            aux_alarm_output_invert    <= 1'b0;
            analog_input_en            <= 1'b0;
            ext_dac_en                 <= 1'b0;
            nominal_60hz               <= 1'b0;
            voltage_ref                <= 16'h0000;
            voltage_ref_source         <= 2'h0;
            voltage_ref_clamped        <= 1'b0;
            ref_setting                <= 16'h0000;
            stability_setting          <= 16'h0000;
            underspeed_setting         <= 16'h0000;
            excitation_current_setting <= 16'h0000;
        end else begin
            true_rms_regulation     <= config_reg[`CWRS_BIT_RMS]; // R1
            periodic_ref_en         <= config_reg[`CWRS_BIT_PERIODIC];
            offset_comp_en          <= config_reg[`CWRS_BIT_OFFSET_COMP]; // R4
            last32_samples_en       <= config_reg[`CWRS_BIT_LAST32]; // R5
            aux_alarm_output_invert <= config_reg[`CWRS_BIT_ALARM_INV];
            analog_input_en         <= config_reg[`CWRS_BIT_ANALOG_EN]; // R6
            ext_dac_en              <= config_reg[`CWRS_BIT_DAC_EN];
            // jumper wins when enabled; otherwise the word chooses
            nominal_60hz <= jumper_en_s ? jumper_60_s : config_reg[`CWRS_BIT_SEL_60HZ]; // R7
            voltage_ref         <= sel_ref; // R15
            voltage_ref_source  <= sel_src;
            voltage_ref_clamped <= sel_clamp;
            ref_setting <= config_reg[`CWRS_BIT_TRIM_VOLTAGE_TRIM] ? trim_voltage_trim_s : trim_param_reg[0]; // R14
            stability_setting <= config_reg[`CWRS_BIT_TRIM_STABILITY_TRIM] ? trim_stability_trim_s
                                                                 : trim_param_reg[1]; // R14
            underspeed_setting <= config_reg[`CWRS_BIT_TRIM_HZ] ? trim_hz_s
                                                                : trim_param_reg[2]; // R14
            excitation_current_setting <= config_reg[`CWRS_BIT_TRIM_AMP] ? trim_amp_s
                                                                         : trim_param_reg[3]; // R14
        end
    end

endmodule // cwrs_config_bank

// ==== tb/cwrs_config_bank_chk.sv ====
// concurrent checks on the config/reference bank ports
`timescale 1ns/1ps
module cwrs_config_bank_chk (
    // clock and reset
    input logic        aclk,
    input logic        aresetn,
    // register bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    // pins and regulator side
    input logic        analog_lost_pin,
    input logic        freq_jumper_en_pin,
    input logic        freq_jumper_60_pin,
    input logic        analog_input_en,
    input logic        nominal_60hz,
    input logic [1:0]  voltage_ref_source,
    input logic        voltage_ref_clamped
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_src_an; voltage_ref_source[1] == analog_input_en; endproperty
    a_src_an: assert property (p_src_an)
        else $error("source does not follow analogue enable");
    property p_clamp_mode; voltage_ref_clamped |-> voltage_ref_source == 2'h3; endproperty
    a_clamp_mode: assert property (p_clamp_mode)
        else $error("clamp outside saturation mode");
    // five samples cover the two-flop synchroniser plus output register
    property p_lost;
        (voltage_ref_source == 2'h3 && analog_lost_pin)[*5] |-> voltage_ref_clamped;
    endproperty
    a_lost: assert property (p_lost)
        else $error("lost link not clamped");
    property p_60on; (freq_jumper_en_pin && freq_jumper_60_pin)[*5] |-> nominal_60hz; endproperty
    a_60on: assert property (p_60on)
        else $error("jumper 60 Hz ignored");
    property p_60off; (freq_jumper_en_pin && !freq_jumper_60_pin)[*5] |-> !nominal_60hz; endproperty
    a_60off: assert property (p_60off)
        else $error("jumper 50 Hz ignored");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write response late");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read data late");
    property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_one: assert property (p_b_one)
        else $error("write response repeated");
    property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_arready; endproperty
    a_r_upper: assert property (p_r_upper)
        else $error("read upper half not zero");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block)
        else $error("write taken during response");
endmodule // cwrs_config_bank_chk
bind cwrs_config_bank cwrs_config_bank_chk u_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .analog_lost_pin, .freq_jumper_en_pin, .freq_jumper_60_pin, .analog_input_en,
    .nominal_60hz, .voltage_ref_source, .voltage_ref_clamped);

// ==== tb/config_word_reference_select_test.sv ====
// self-checking bench for the config word and reference select bank
`timescale 1ns/1ps
`include "cwrs_consts.vh"
`define CHK(a, e) begin logic [63:0] ce; ce = (e); comparisons++; if ((a) !== ce) begin \
    err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), ce); end end
module config_word_reference_select_test;
    logic        aclk = 0, aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1;
    logic        analog_at_limit_pin = 0, analog_lost_pin = 0;
    logic        freq_jumper_en_pin = 0, freq_jumper_60_pin = 0;
    logic [15:0] analog_value_pin = 0, voltage_trim, stability_trim;
    logic [15:0] underspeed_trim, excitation_current_trim;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, voltage_ref_source;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        true_rms_regulation, periodic_ref_en, offset_comp_en, last32_samples_en;
    logic        aux_alarm_output_invert, analog_input_en, ext_dac_en, nominal_60hz;
    logic        voltage_ref_clamped;
    logic [15:0] voltage_ref, ref_setting, stability_setting, underspeed_setting;
    logic [15:0] excitation_current_setting, cfg;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          err_total, comparisons, cyc;
    integer      seed = 32'h8344;
    cwrs_config_bank DUT (.*);
    always #50 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    // answers are matched in issue order against the notes queued by the tasks
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input [7:0] i, input [15:0] d, input [3:0] s, input [1:0] r);
        bq.push_back(r);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd(input [7:0] i, input [15:0] e, input [1:0] r);
        rq.push_back({r, 16'h0000, e});
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask
    // four edges: commit, output register and the pin synchronisers
    task automatic chk_out();
        repeat (4) @(posedge aclk);
        `CHK({ext_dac_en, aux_alarm_output_invert, last32_samples_en, offset_comp_en,
            periodic_ref_en, true_rms_regulation, analog_input_en},
            {cfg[13], cfg[5], cfg[3:0], cfg[12]})
        `CHK(voltage_ref_source, {cfg[12], cfg[7]})
        `CHK(nominal_60hz, freq_jumper_en_pin ? freq_jumper_60_pin : cfg[14])
        `CHK({ref_setting, stability_setting, underspeed_setting, excitation_current_setting},
            {cfg[8] ? voltage_trim : 16'h0000, cfg[9] ? stability_trim : 16'h4000,
            cfg[10] ? underspeed_trim : 16'h4000,
            cfg[11] ? excitation_current_trim : 16'h4000})
    endtask
    task automatic wcfg(input [15:0] v);
        cfg = v;
        wr(`CWRS_IDX_CONFIG, v, 4'h3, `CWRS_AXI_OKAY);
        chk_out();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        voltage_trim <= $random(seed);
        stability_trim <= $random(seed);
        underspeed_trim <= $random(seed);
        excitation_current_trim <= $random(seed);
        cfg = 16'h1F3D;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_out();
        rd(`CWRS_IDX_CONFIG, 16'h1F3D, `CWRS_AXI_OKAY);
        rd(`CWRS_IDX_STORED_REF, 16'h4000, `CWRS_AXI_OKAY);
        rd(`CWRS_IDX_VAR_LIMIT, 16'h1200, `CWRS_AXI_OKAY);
        rd(8'h20, 16'h0000, `CWRS_AXI_SLVERR);
        wr(8'h20, 16'hFFFF, 4'h3, `CWRS_AXI_SLVERR);
        $display("test reset values done");
        for (int b = 0; b < 16; b++) wcfg(16'h1F3D ^ (16'h0001 << b));
        wcfg(16'h100D);
        rd(`CWRS_IDX_CONFIG, 16'h100D, `CWRS_AXI_OKAY);
        wr(`CWRS_IDX_CONFIG, 16'hFFFF, 4'h1, `CWRS_AXI_OKAY);
        cfg = 16'h10FF;
        chk_out();
        rd(`CWRS_IDX_CONFIG, 16'h10FF, `CWRS_AXI_OKAY);
        $display("test bit functions done");
        for (int j = 0; j < 4; j++) begin
            freq_jumper_en_pin <= j[1];
            freq_jumper_60_pin <= j[0];
            wcfg(j[0] ? 16'h0000 : 16'h4000);
            rd(`CWRS_IDX_STATUS_CFG, {1'b0, j[1] ~^ j[0], 14'h0}, `CWRS_AXI_OKAY);
        end
        freq_jumper_en_pin <= 1'b0;
        $display("test frequency select done");
        wcfg(16'h0000);
        wr(`CWRS_IDX_VOLATILE_REF, 16'h1234, 4'h3, `CWRS_AXI_OKAY);
        rd(`CWRS_IDX_VOLATILE_REF, 16'h4000, `CWRS_AXI_OKAY);
        wr(`CWRS_IDX_STORED_REF, 16'h2222, 4'h3, `CWRS_AXI_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(voltage_ref, 16'h2222)
        rd(`CWRS_IDX_ACTIVE_REF, 16'h2222, `CWRS_AXI_OKAY);
        wcfg(16'h0080);
        wr(`CWRS_IDX_VOLATILE_REF, 16'h3456, 4'h3, `CWRS_AXI_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(voltage_ref, 16'h3456)
        rd(`CWRS_IDX_ACTIVE_REF, 16'h3456, `CWRS_AXI_OKAY);
        $display("test digital reference done");
        analog_value_pin <= $random(seed) & 16'h3FFF;
        analog_at_limit_pin <= 1'b1;
        wcfg(16'h1000);
        `CHK({voltage_ref_clamped, voltage_ref}, {1'b0, analog_value_pin})
        wcfg(16'h1080);
        `CHK({voltage_ref_clamped, voltage_ref}, {1'b1, 16'h5200})
        rd(`CWRS_IDX_REF_STATUS, 16'h0007, `CWRS_AXI_OKAY);
        analog_at_limit_pin <= 1'b0;
        analog_lost_pin <= 1'b1;
        chk_out();
        `CHK({voltage_ref_clamped, voltage_ref}, {1'b1, 16'h5200})
        @(posedge aclk);
        analog_lost_pin <= 1'b0;
        chk_out();
        `CHK({voltage_ref_clamped, voltage_ref}, {1'b0, analog_value_pin})
        $display("test analogue reference done");
        tally_and_finish();
    end
endmodule // config_word_reference_select_test
